// ===== sutc_defines.svh
// sutc_defines.svh: register offsets, field positions and frame counts of the serial block
`ifndef SUTC_DEFINES_SVH
`define SUTC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SUTC_OFF_CTL1     8'h00
`define SUTC_OFF_CTL2     8'h04
`define SUTC_OFF_STS1     8'h08
`define SUTC_OFF_DATA     8'h0C
`define SUTC_OFF_EVT      8'h10
`define SUTC_OFF_EVTMASK  8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SUTC_C1_LOOP  7
`define SUTC_C1_NINE  4
`define SUTC_C1_WAKE  3
`define SUTC_C1_LBRK  2
`define SUTC_C2_TIE   7
`define SUTC_C2_TCIE  6
`define SUTC_C2_RIE   5
`define SUTC_C2_TE    3
`define SUTC_C2_RE    2
`define SUTC_C2_RWU   1
`define SUTC_C2_SBK   0
`define SUTC_S1_TX_BUFFER_EMPTY  7
`define SUTC_S1_TC    6
`define SUTC_S1_RX_BUFFER_FULL  5
`define SUTC_EV_TX_BUFFER_EMPTY  0
`define SUTC_EV_TC    1
`define SUTC_EV_RX_BUFFER_FULL  2
`define SUTC_EV_WAKE  3

// ----------------------------------------------------------------
// frame lengths in bit times
// ----------------------------------------------------------------
`define SUTC_FRAME8   4'hA
`define SUTC_FRAME9   4'hB
`define SUTC_BRK8     4'hA
`define SUTC_BRK9     4'hB
`define SUTC_LBRK8    4'hD
`define SUTC_LBRK9    4'hE
`define SUTC_RXBITS8  4'h9
`define SUTC_RXBITS9  4'hA

`endif

// ===== sutc_pkg.sv
// sutc_pkg.sv: types of the serial control and status block
package sutc_pkg;

    typedef enum logic {TX_IDLE, TX_SEND} sutc_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sutc_rx_e;

    typedef struct packed {
        logic loop;
        logic nine;
        logic wake;
        logic lbrk;
        logic [7:0] ctl2;
        logic tx_buffer_empty;
        logic tc;
        logic rx_buffer_full;
        logic arm_tx_buffer_empty;
        logic arm_tc;
        logic arm_rx_buffer_full;
        logic [8:0] tx_buf;
        logic [13:0] tx_sh;
        sutc_tx_e tx_st;
        logic [3:0] tx_bits;
        logic [15:0] tx_cnt;
        logic pre_pend;
        logic brk_pend;
        logic txd;
        logic txd_oe;
        sutc_rx_e rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [9:0] rx_sh;
        logic [8:0] rx_data;
        logic [19:0] idle_cnt;
        logic idle_done;
        logic [3:0] evt;
        logic [3:0] evt_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic rx_own;
    } sutc_state_s;

endpackage

// ===== sutc_serial.sv
// sutc_serial.sv: serial transmit/receive control and status flags behind an APB slave
//
// Behaviour
// - receiver off releases the receive pin
// - loop mode releases receive pin regardless
// - standby bit set puts receiver in standby
// - wakeup by idle line or address mark
// - wakeup clears standby bit automatically
// - break-queue write one then zero sends break
// - break is 10/11 or 13/14 zero bits
// - second break may queue before clear
// - tx empty set at reset and load
// - tx empty cleared by status read, data write
// - tx complete set when fully idle
// - tx complete cleared by three armed actions
// - rx full set on received character
// - rx full cleared by status read, data read
// - status register read-only, writes ignored
// - transmitter works and drives pin when on
// - flags with enables request interrupt
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps

`include "sutc_defines.svh"

module sutc_serial
    import sutc_pkg::*;
#(
    parameter int BIT_CYCLES = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic rxd_in,
    output logic rx_pin_own,
    output logic txd_out,
    output logic txd_oe,
    // interrupt
    output logic irq
);

    localparam logic [15:0] BIT_M1 = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);
    localparam logic [19:0] IDLE8 = 20'(int'(`SUTC_FRAME8) * BIT_CYCLES);
    localparam logic [19:0] IDLE9 = 20'(int'(`SUTC_FRAME9) * BIT_CYCLES);

    sutc_state_s s_r;
    sutc_state_s s_nxt;

    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic tx_on;
    logic break_queue;
    logic line;
    logic tc_cond;
    logic [31:0] rdv;
    logic [9:0] rx_tmp;
    logic [8:0] rx_char;

    always_comb begin
        s_nxt = s_r;
        rdv = 32'h0;
        rx_tmp = 10'h0;
        rx_char = 9'h0;
        setup = psel & ~penable;
        acc = psel & penable & s_r.pready;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        tx_on = s_r.ctl2[`SUTC_C2_TE];
        break_queue = s_r.ctl2[`SUTC_C2_SBK];
        line = s_r.loop ? s_r.txd : rxd_in;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;

        // ----------------------------------------------------------------
        // read data is captured in the setup cycle, so pready can come from a flop
        // ----------------------------------------------------------------
        if (setup) begin
            s_nxt.pready = 1'b1;
            unique case (paddr)
                `SUTC_OFF_CTL1: begin
                    rdv[`SUTC_C1_LOOP] = s_r.loop;
                    rdv[`SUTC_C1_NINE] = s_r.nine;
                    rdv[`SUTC_C1_WAKE] = s_r.wake;
                    rdv[`SUTC_C1_LBRK] = s_r.lbrk;
                end
                `SUTC_OFF_CTL2: rdv[7:0] = s_r.ctl2;
                `SUTC_OFF_STS1: begin
                    rdv[`SUTC_S1_TX_BUFFER_EMPTY] = s_r.tx_buffer_empty;
                    rdv[`SUTC_S1_TC] = s_r.tc;
                    rdv[`SUTC_S1_RX_BUFFER_FULL] = s_r.rx_buffer_full;
                end
                `SUTC_OFF_DATA: rdv[8:0] = s_r.rx_data;
                `SUTC_OFF_EVT: rdv[3:0] = s_r.evt;
                `SUTC_OFF_EVTMASK: rdv[3:0] = s_r.evt_mask;
                default: s_nxt.pslverr = 1'b1;
            endcase
            s_nxt.prdata = rdv;
        end

        // ----------------------------------------------------------------
        // register writes and read side effects
        // ----------------------------------------------------------------
        // arming uses the value software actually saw in prdata
        if (rd && paddr == `SUTC_OFF_STS1) begin
            if (s_r.prdata[`SUTC_S1_TX_BUFFER_EMPTY]) s_nxt.arm_tx_buffer_empty = 1'b1;
            if (s_r.prdata[`SUTC_S1_TC]) s_nxt.arm_tc = 1'b1;
            if (s_r.prdata[`SUTC_S1_RX_BUFFER_FULL]) s_nxt.arm_rx_buffer_full = 1'b1;
        end
        if (rd && paddr == `SUTC_OFF_DATA && s_r.arm_rx_buffer_full) begin
            s_nxt.rx_buffer_full = 1'b0;
            s_nxt.arm_rx_buffer_full = 1'b0;
        end
        if (wr) begin
            unique case (paddr)
                `SUTC_OFF_CTL1: begin
                    s_nxt.loop = pwdata[`SUTC_C1_LOOP];
                    s_nxt.nine = pwdata[`SUTC_C1_NINE];
                    s_nxt.wake = pwdata[`SUTC_C1_WAKE];
                    s_nxt.lbrk = pwdata[`SUTC_C1_LBRK];
                end
                `SUTC_OFF_CTL2: begin
                    s_nxt.ctl2 = pwdata[7:0];
                    if (!tx_on && pwdata[`SUTC_C2_TE]) begin
                        s_nxt.pre_pend = 1'b1;
                        if (s_r.arm_tc) begin
                            s_nxt.tc = 1'b0;
                            s_nxt.arm_tc = 1'b0;
                        end
                    end
                    if (pwdata[`SUTC_C2_SBK]) begin
                        s_nxt.brk_pend = 1'b1;
                        if (s_r.arm_tc) begin
                            s_nxt.tc = 1'b0;
                            s_nxt.arm_tc = 1'b0;
                        end
                    end
                end
                `SUTC_OFF_DATA: begin
                    s_nxt.tx_buf = pwdata[8:0];
                    if (s_r.arm_tx_buffer_empty) begin
                        s_nxt.tx_buffer_empty = 1'b0;
                        s_nxt.arm_tx_buffer_empty = 1'b0;
                    end
                    if (s_r.arm_tc) begin
                        s_nxt.tc = 1'b0;
                        s_nxt.arm_tc = 1'b0;
                    end
                end
                `SUTC_OFF_EVT: s_nxt.evt = s_r.evt & ~pwdata[3:0];
                `SUTC_OFF_EVTMASK: s_nxt.evt_mask = pwdata[3:0];
                // status one ignores writes
                default: s_nxt.ctl2 = s_nxt.ctl2;
            endcase
        end

        // ----------------------------------------------------------------
        // transmitter
        // ----------------------------------------------------------------
        // a frame in flight always finishes, even after the enable drops
        unique case (s_r.tx_st)
            TX_IDLE: begin
                if (tx_on) begin
                    s_nxt.tx_cnt = BIT_M1;
                    if (s_r.pre_pend) begin
                        s_nxt.tx_st = TX_SEND;
                        s_nxt.tx_sh = 14'h3FFF;
                        s_nxt.tx_bits = s_r.nine ? `SUTC_FRAME9 : `SUTC_FRAME8;
                        s_nxt.pre_pend = 1'b0;
                    end else if (s_r.brk_pend || break_queue) begin
                        // a bit still set when the break ends queues the next one
                        s_nxt.tx_st = TX_SEND;
                        s_nxt.tx_sh = 14'h0;
                        if (s_r.lbrk) begin
                            s_nxt.tx_bits = s_r.nine ? `SUTC_LBRK9 : `SUTC_LBRK8;
                        end else begin
                            s_nxt.tx_bits = s_r.nine ? `SUTC_BRK9 : `SUTC_BRK8;
                        end
                        s_nxt.brk_pend = 1'b0;
                    end else if (!s_r.tx_buffer_empty) begin
                        s_nxt.tx_st = TX_SEND;
                        if (s_r.nine) begin
                            s_nxt.tx_sh = {3'h7, s_r.tx_buf, 1'b0};
                            s_nxt.tx_bits = `SUTC_FRAME9;
                        end else begin
                            s_nxt.tx_sh = {5'h1F, s_r.tx_buf[7:0], 1'b0};
                            s_nxt.tx_bits = `SUTC_FRAME8;
                        end
                        s_nxt.tx_buffer_empty = 1'b1;
                        s_nxt.evt[`SUTC_EV_TX_BUFFER_EMPTY] = 1'b1;
                    end
                end
            end
            TX_SEND: begin
                if (s_r.tx_cnt == 16'h0) begin
                    s_nxt.tx_cnt = BIT_M1;
                    s_nxt.tx_sh = {1'b1, s_r.tx_sh[13:1]};
                    s_nxt.tx_bits = s_r.tx_bits - 4'h1;
                    if (s_r.tx_bits == 4'h1) s_nxt.tx_st = TX_IDLE;
                end else begin
                    s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
                end
            end
        endcase
        s_nxt.txd = (s_nxt.tx_st == TX_SEND) ? s_nxt.tx_sh[0] : 1'b1;
        s_nxt.txd_oe = s_nxt.ctl2[`SUTC_C2_TE] | (s_nxt.tx_st == TX_SEND);

        // ----------------------------------------------------------------
        // receiver
        // ----------------------------------------------------------------
        if (!s_r.ctl2[`SUTC_C2_RE]) begin
            s_nxt.rx_st = RX_IDLE;
            s_nxt.idle_cnt = 20'h0;
        end else begin
            unique case (s_r.rx_st)
                RX_IDLE: begin
                    if (!line) begin
                        s_nxt.rx_st = RX_START;
                        s_nxt.rx_cnt = BIT_HALF;
                        s_nxt.idle_cnt = 20'h0;
                        s_nxt.idle_done = 1'b0;
                    end else if (!s_r.idle_done) begin
                        s_nxt.idle_cnt = s_r.idle_cnt + 20'h1;
                        if (s_nxt.idle_cnt >= (s_r.nine ? IDLE9 : IDLE8)) begin
                            s_nxt.idle_done = 1'b1;
                            if (s_r.ctl2[`SUTC_C2_RWU] && !s_r.wake) begin
                                s_nxt.ctl2[`SUTC_C2_RWU] = 1'b0;
                                s_nxt.evt[`SUTC_EV_WAKE] = 1'b1;
                            end
                        end
                    end
                end
                RX_START: begin
                    if (s_r.rx_cnt == 16'h0) begin
                        // a glitch shorter than half a bit is not a start bit
                        s_nxt.rx_st = line ? RX_IDLE : RX_BITS;
                        s_nxt.rx_cnt = BIT_M1;
                        s_nxt.rx_bits = s_r.nine ? `SUTC_RXBITS9 : `SUTC_RXBITS8;
                    end else begin
                        s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
                    end
                end
                RX_BITS: begin
                    if (s_r.rx_cnt == 16'h0) begin
                        rx_tmp = {line, s_r.rx_sh[9:1]};
                        s_nxt.rx_sh = rx_tmp;
                        s_nxt.rx_cnt = BIT_M1;
                        s_nxt.rx_bits = s_r.rx_bits - 4'h1;
                        if (s_r.rx_bits == 4'h1) begin
                            s_nxt.rx_st = RX_IDLE;
                            rx_char = s_r.nine ? rx_tmp[8:0] : {1'b0, rx_tmp[8:1]};
                            // in standby only an address mark gets through
                            if (!s_r.ctl2[`SUTC_C2_RWU] || (s_r.wake && rx_tmp[8])) begin
                                if (s_r.ctl2[`SUTC_C2_RWU]) begin
                                    s_nxt.ctl2[`SUTC_C2_RWU] = 1'b0;
                                    s_nxt.evt[`SUTC_EV_WAKE] = 1'b1;
                                end
                                s_nxt.rx_data = rx_char;
                                s_nxt.rx_buffer_full = 1'b1;
                                s_nxt.evt[`SUTC_EV_RX_BUFFER_FULL] = 1'b1;
                            end
                        end
                    end else begin
                        s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
                    end
                end
                default: s_nxt.rx_st = RX_IDLE;
            endcase
        end
        s_nxt.rx_own = s_nxt.ctl2[`SUTC_C2_RE] & ~s_nxt.loop;

        // ----------------------------------------------------------------
        // completion flag and interrupt
        // ----------------------------------------------------------------
        // judged on next-state values so a clearing access is not undone at once
        tc_cond = s_nxt.tx_buffer_empty & (s_nxt.tx_st == TX_IDLE) & ~s_nxt.pre_pend & ~s_nxt.brk_pend
                  & ~(s_nxt.ctl2[`SUTC_C2_SBK] & s_nxt.ctl2[`SUTC_C2_TE]);
        if (tc_cond) begin
            s_nxt.tc = 1'b1;
            if (!s_r.tc) s_nxt.evt[`SUTC_EV_TC] = 1'b1;
        end
        s_nxt.irq = (|(s_nxt.evt & s_nxt.evt_mask))
                    | (s_nxt.tx_buffer_empty & s_nxt.ctl2[`SUTC_C2_TIE])
                    | (s_nxt.tc & s_nxt.ctl2[`SUTC_C2_TCIE])
                    | (s_nxt.rx_buffer_full & s_nxt.ctl2[`SUTC_C2_RIE]);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.tx_buffer_empty <= 1'b1;
            s_r.tc <= 1'b1;
            s_r.txd <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign rx_pin_own = s_r.rx_own;
    assign txd_out = s_r.txd;
    assign txd_oe = s_r.txd_oe;
    assign irq = s_r.irq;

endmodule

// ===== sutc_serial_props.sv
// sutc_serial_props.sv: bus, pin and break checks on the serial control block
`timescale 1ns/100ps
module sutc_serial_props #(
    parameter int BIT_CYCLES = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial pins and interrupt
    input wire logic rxd_in,
    input wire logic rx_pin_own,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic irq
);
    logic acc;
    logic [15:0] low_r;
    assign acc = psel && penable && pready;
    // low run of the transmit line; a break that never ends shows up here
    always_ff @(posedge clk)
        low_r <= (!rstn || txd_out) ? 16'h0 : low_r + 16'h1;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_setup_answer: assert property (psel && !penable |=> pready && penable)
        else $error("access cycle without ready");
    chk_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    chk_status_ro_bits: assert property (acc && !pwrite && paddr == 8'h08 |-> prdata[31:8] == 24'h0 && prdata[4:0] == 5'h0)
        else $error("status word carries stray bits");
    chk_rx_off_release: assert property (acc && pwrite && paddr == 8'h04 && !pwdata[2] |-> ##2 !rx_pin_own)
        else $error("receive pin kept while receiver off");
    chk_loop_release: assert property (acc && pwrite && paddr == 8'h00 && pwdata[7] |-> ##2 !rx_pin_own)
        else $error("receive pin kept in loop mode");
    chk_tx_on_drives: assert property (acc && pwrite && paddr == 8'h04 && pwdata[3] |-> ##2 txd_oe)
        else $error("transmit pin not driven while on");
    chk_low_driven: assert property (!txd_out |-> txd_oe)
        else $error("low level on undriven transmit pin");
    chk_break_len: assert property (low_r <= 16'(14 * BIT_CYCLES))
        else $error("low run longer than longest break");
    cover property (acc && pwrite && paddr == 8'h04 && pwdata[0]);
    cover property ($rose(irq));
    cover property (low_r == 16'(13 * BIT_CYCLES));
endmodule

bind sutc_serial sutc_serial_props #(.BIT_CYCLES(BIT_CYCLES)) u_sutc_serial_props (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .rx_pin_own(rx_pin_own), .txd_out(txd_out),
    .txd_oe(txd_oe), .irq(irq));

// ===== sutc_remote.sv
// sutc_remote.sv: behavioural far-end serial node
`timescale 1ns/100ps
module sutc_remote #(
    parameter int BIT = 16
) (
    // clock reference
    input wire logic clk,
    // serial lines
    input wire logic txd,
    output logic rxd
);
    logic [7:0] ch, last_ch;
    int run, last_low, i;
    initial rxd = 1'h1;
    always @(posedge clk) begin
        run <= txd ? 0 : run + 1;
        if (txd && run != 0)
            last_low <= run;
    end
    // mid-bit sampling; a break decodes as junk, so only plain frames are judged
    always @(posedge clk) if (!txd) begin
        repeat (BIT / 2) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            ch[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        last_ch = ch;
    end
    task automatic send(input logic [7:0] d);
        rxd <= 1'h0;
        repeat (BIT) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            rxd <= d[k];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'h1;
        repeat (2 * BIT) @(posedge clk);
    endtask
endmodule

// ===== sutc_serial_bench.sv
// sutc_serial_bench.sv: self-checking testbench of the serial control block
`timescale 1ns/100ps
module sutc_serial_bench;
    localparam int BC = 4;
    localparam logic [7:0] C1 = 8'h00, C2 = 8'h04, ST = 8'h08, DT = 8'h0C, EV = 8'h10, EM = 8'h14;
    logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, rxd_in, rx_pin_own, txd_out, txd_oe, irq;
    int fail_count = 0, n_checks = 0;
    // pulled-up line: an undriven transmit pin reads high
    wire tx_line = txd_oe ? txd_out : 1'h1;
    always #5 clk = ~clk;
    sutc_serial #(.BIT_CYCLES(BC)) u_sutc_serial (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd_in(rxd_in), .rx_pin_own(rx_pin_own), .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq));
    sutc_remote #(.BIT(BC)) u_sutc_remote (.clk(clk), .txd(tx_line), .rxd(rxd_in));
    task automatic test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // look at the answer where it has settled; the next rising edge is the one that takes it
        @(negedge clk);
        while (pready !== 1'h1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        fail_count += (n == 20);
        rdv = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'h1, a, d); endtask
    task automatic rd(input logic [7:0] a); apb(1'h0, a, 32'h0); endtask
    task automatic w(input int n); repeat (n) @(posedge clk); endtask
    task automatic poll_tc;
        for (int k = 0; k < 200 && rdv[6] !== 1'h1; k++)
            rd(ST);
        chk("tc_poll", 32'h1, {31'h0, rdv[6]});
        w(2);
    endtask
    task automatic t_reset;
        chk("pins", 3'h0, {irq, txd_oe, rx_pin_own});
        rd(ST);
        chk("status", 32'hC0, rdv);
        wr(ST, 32'h0);
        rd(ST);
        chk("status_wr", 32'hC0, rdv);
        rd(8'h40);
        chk("bad_rdata", 32'h0, rdv);
        chk("bad_err", 32'h1, {31'h0, err});
    endtask
    task automatic t_tx;
        wr(C2, 32'h08);
        rd(ST);
        chk("tc_pre", 1'h0, rdv[6]);
        chk("oe", 1'h1, txd_oe);
        poll_tc();
        wr(DT, 32'hA5);
        rd(ST);
        wr(DT, 32'h3C);
        rd(ST);
        chk("tx_buffer_empty_tc", 2'h0, rdv[7:6]);
        poll_tc();
        chk("status_idle", 32'hC0, rdv);
        chk("tx_char", 8'h3C, u_sutc_remote.last_ch);
    endtask
    task automatic t_break;
        for (int k = 0; k < 2; k++) begin
            wr(C1, k ? 32'h04 : 32'h00);
            rd(ST);
            wr(C2, 32'h09);
            wr(C2, 32'h08);
            rd(ST);
            chk("tc_brk", 1'h0, rdv[6]);
            poll_tc();
            chk("brk_len", k ? 13 * BC : 10 * BC, u_sutc_remote.last_low);
        end
    endtask
    task automatic t_rx;
        wr(C1, 32'h80);
        wr(C2, 32'h04);
        w(2);
        chk("own_loop", 1'h0, rx_pin_own);
        wr(C1, 32'h00);
        wr(EV, 32'hF);
        wr(EM, 32'h4);
        chk("own", 1'h1, rx_pin_own);
        u_sutc_remote.send(8'h3C);
        rd(ST);
        chk("rx_buffer_full", 2'h3, {rdv[5], irq});
        wr(EM, 32'h0);
        wr(EV, 32'h4);
        rd(EV);
        chk("evt_irq", 2'h0, {rdv[2], irq});
        wr(C2, 32'h24);
        w(2);
        chk("irq_rie", 1'h1, irq);
        rd(DT);
        chk("rx_char", 32'h3C, rdv);
        rd(ST);
        w(1);
        chk("rx_buffer_full_clr", 2'h0, {rdv[5], irq});
        u_sutc_remote.send(8'h5A);
        rd(DT);
        rd(ST);
        chk("rx_buffer_full_kept", 1'h1, rdv[5]);
        rd(DT);
        rd(ST);
        chk("rx_buffer_full_clr2", 1'h0, rdv[5]);
    endtask
    task automatic t_standby;
        wr(C1, 32'h08);
        wr(C2, 32'h06);
        u_sutc_remote.send(8'h12);
        rd(ST);
        chk("sb_drop", 1'h0, rdv[5]);
        u_sutc_remote.send(8'h92);
        rd(C2);
        chk("sb_wake", 1'h0, rdv[1]);
        rd(DT);
        chk("sb_char", 32'h92, rdv);
        wr(C1, 32'h00);
        wr(C2, 32'h06);
        w(12 * BC);
        rd(C2);
        chk("idle_wake", 1'h0, rdv[1]);
    endtask
    initial begin
        w(2);
        rstn <= 1'h1;
        w(1);
        t_reset();
        t_tx();
        t_break();
        t_rx();
        t_standby();
        test_done();
    end
    // generous ceiling: the whole sequence needs well under a thousand cycles
    initial begin
        #500000;
        fail_count++;
        test_done();
    end
endmodule
